// ===== design/bwmb_pkg.sv
// package for the byte-to-word mailbox bridge: widths, timing, states
// assumes one 40 MHz system clock shared by all users
`default_nettype none
package bwmb_pkg;
	localparam int BWMB_BYTE_W = 8;
	localparam int BWMB_WORD_W = 16;
	localparam int BWMB_CLK_MHZ = 40;
	// processor read timeout in microseconds, and its cycle count
	localparam int BWMB_TIMEOUT_US = 200;
	localparam int BWMB_TIMEOUT_CYC = BWMB_TIMEOUT_US * BWMB_CLK_MHZ;
	localparam int BWMB_CNT_W = 16;
	localparam logic [0:0] BWMB_SEL_LO = 1'h0;
	localparam logic [0:0] BWMB_SEL_HI = 1'h1;
	typedef enum logic [1:0] {
		BWMB_TX_IDLE = 2'h0,
		BWMB_TX_LOW = 2'h1,
		BWMB_TX_FULL = 2'h3
	} bwmb_tx_e;
endpackage
`default_nettype wire

// ===== design/bwmb_word_reg.sv
// one 16-bit holding word written as a whole or one byte at a time
// assumes writers on the system clock
`default_nettype none
module bwmb_word_reg
	import bwmb_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// write side
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [BWMB_BYTE_W-1:0] wr_byte,
	input wire logic wr_word,
	input wire logic [BWMB_WORD_W-1:0] wr_data,
	// stored word
	output logic [BWMB_WORD_W-1:0] word_q
);
	logic [BWMB_WORD_W-1:0] word_reg;
	logic [BWMB_WORD_W-1:0] word_next;

	assign word_next = wr_word ? wr_data :
		{wr_hi ? wr_byte : word_reg[15:8], wr_lo ? wr_byte : word_reg[7:0]};

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			word_reg <= 16'h0000;
		else
			word_reg <= word_next;
	end

	assign word_q = word_reg;
endmodule // bwmb_word_reg
`default_nettype wire

// ===== design/bwmb_bridge.sv
// byte-to-word mailbox bridge between an 8-bit controller bus and a
// 16-bit modulator processor port; both parties on clk_sys
`default_nettype none
// How it works
// R1 - the bridge joins an 8-bit controller bus to a 16-bit processor port and carries whole words.
// R2 - the controller moves each word as a low byte access and a high byte access.
// R3 - two data-available flags are driven out and seen by both parties.
// R4 - a controller-bound flag rises once the processor has deposited a word.
// R5 - a processor-bound flag stands while a controller word awaits the processor.
// R6 - a word left unread by the processor raises a processor communications fault.
// R7 - the processor exchanges all commands and status through its 16-bit port.
// R8 - flags set after the whole word is written, clear on the full read, fault after a timeout.
module bwmb_bridge
	import bwmb_pkg::*;
#(
	parameter int TIMEOUT_CYC = BWMB_TIMEOUT_CYC
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// controller byte bus
	input wire logic mcu_wr,
	input wire logic mcu_rd,
	input wire logic mcu_sel,
	input wire logic [BWMB_BYTE_W-1:0] mcu_wdata,
	output logic [BWMB_BYTE_W-1:0] mcu_rdata,
	// processor word port
	input wire logic proc_wr,
	input wire logic proc_rd,
	input wire logic [BWMB_WORD_W-1:0] proc_wdata,
	output logic [BWMB_WORD_W-1:0] proc_rdata,
	// status seen by both sides
	output logic avail_to_mcu,
	output logic avail_to_proc,
	output logic proc_comm_fault,
	input wire logic fault_clr
);
	bwmb_tx_e tx_reg;
	bwmb_tx_e tx_next;
	logic up_full_reg;
	logic [1:0] up_rd_reg;
	logic fault_reg;
	logic [BWMB_CNT_W-1:0] wait_reg;
	logic [BWMB_WORD_W-1:0] down_word;
	logic [BWMB_WORD_W-1:0] up_word;
	logic [BWMB_BYTE_W-1:0] mcu_rdata_reg;
	logic [BWMB_WORD_W-1:0] proc_rdata_reg;

	// one select compare shared by all four strobes
	function automatic logic strobe_on(input logic strobe, input logic sel, input logic [0:0] want);
		return strobe && (sel == want);
	endfunction

	// decode of controller strobes
	wire mcu_wr_lo = strobe_on(mcu_wr, mcu_sel, BWMB_SEL_LO);
	wire mcu_wr_hi = strobe_on(mcu_wr, mcu_sel, BWMB_SEL_HI);
	wire mcu_rd_lo = strobe_on(mcu_rd, mcu_sel, BWMB_SEL_LO);
	wire mcu_rd_hi = strobe_on(mcu_rd, mcu_sel, BWMB_SEL_HI);
	wire down_full = (tx_reg == BWMB_TX_FULL);
	wire proc_take = proc_rd && down_full;
	wire proc_put = proc_wr && !up_full_reg;
	wire up_done = up_full_reg && (up_rd_reg == 2'h3);
	wire timed_out = down_full && (wait_reg == BWMB_CNT_W'(TIMEOUT_CYC - 1));

	// controller to processor word, byte at a time
	bwmb_word_reg u_down
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wr_lo(mcu_wr_lo && !down_full), // see R2
		.wr_hi(mcu_wr_hi && !down_full),
		.wr_byte(mcu_wdata),
		.wr_word(1'b0),
		.wr_data(16'h0000),
		.word_q(down_word)
	);

	// processor to controller word, whole
	bwmb_word_reg u_up
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.wr_lo(1'b0),
		.wr_hi(1'b0),
		.wr_byte(8'h00),
		.wr_word(proc_put), // see R7
		.wr_data(proc_wdata),
		.word_q(up_word)
	);

	// low byte then high byte; high first restarts nothing, both needed
	always_comb
	begin
		tx_next = tx_reg;
		case (tx_reg)
			BWMB_TX_IDLE:
				if (mcu_wr_lo)
					tx_next = BWMB_TX_LOW;
			BWMB_TX_LOW:
				if (mcu_wr_hi)
					tx_next = BWMB_TX_FULL; // see R8
			BWMB_TX_FULL:
				if (proc_rd)
					tx_next = BWMB_TX_IDLE; // see R5
			default:
				tx_next = BWMB_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			tx_reg <= BWMB_TX_IDLE;
		else
			tx_reg <= tx_next;
	end

	// up flag: set on processor write, clear once both bytes read
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			up_full_reg <= 1'b0;
			up_rd_reg <= 2'h0;
		end
		else if (proc_put)
		begin
			up_full_reg <= 1'b1; // see R4
			up_rd_reg <= 2'h0;
		end
		else if (up_done)
		begin
			up_full_reg <= 1'b0; // see R8
			up_rd_reg <= 2'h0;
		end
		else if (up_full_reg)
			up_rd_reg <= up_rd_reg | {mcu_rd_hi, mcu_rd_lo}; // see R2
	end

	// timeout counter runs only while a word waits for the processor
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			wait_reg <= '0;
		else if (!down_full || proc_take || timed_out)
			wait_reg <= '0;
		else
			wait_reg <= wait_reg + 1'b1;
	end

	// fault is sticky; a new timeout wins over the clear
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			fault_reg <= 1'b0;
		else if (timed_out)
			fault_reg <= 1'b1; // see R6
		else if (fault_clr)
			fault_reg <= 1'b0;
	end

	// registered read data
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mcu_rdata_reg <= 8'h00;
			proc_rdata_reg <= 16'h0000;
		end
		else
		begin
			if (mcu_rd)
				mcu_rdata_reg <= mcu_rd_hi ? up_word[15:8] : up_word[7:0]; // see R1
			if (proc_take)
				proc_rdata_reg <= down_word; // see R1
		end
	end

	assign mcu_rdata = mcu_rdata_reg;
	assign proc_rdata = proc_rdata_reg;
	assign avail_to_mcu = up_full_reg; // see R3
	assign avail_to_proc = down_full; // see R3
	assign proc_comm_fault = fault_reg;

	AST_DOWN_SET: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R5
		(tx_reg == BWMB_TX_LOW) && mcu_wr_hi |=> avail_to_proc)
		else $error("processor flag not set after high byte");
	AST_DOWN_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R8
		proc_take |=> !avail_to_proc && proc_rdata == $past(down_word))
		else $error("processor read did not clear flag or pass word");
	AST_UP_SET: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R4
		proc_put |=> avail_to_mcu && up_word == $past(proc_wdata))
		else $error("controller flag not set on deposit");
	sequence s_both_read;
		up_full_reg && up_rd_reg == 2'h3;
	endsequence
	AST_UP_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R8
		s_both_read and !proc_wr |=> !avail_to_mcu)
		else $error("controller flag not cleared after two reads");
	AST_NO_HALF: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R2
		$rose(avail_to_proc) |-> $past(mcu_wr_hi))
		else $error("processor flag rose without high byte");
	AST_FAULT: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R6
		timed_out |=> proc_comm_fault)
		else $error("fault not raised on timeout");
	AST_FAULT_CAUSE: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R6
		$rose(proc_comm_fault) |-> $past(avail_to_proc))
		else $error("fault without a pending word");
	AST_BYTE_RD: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R1
		mcu_rd_hi |=> mcu_rdata == $past(up_word[15:8]))
		else $error("high byte read wrong");
	AST_DOWN_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R5
		avail_to_proc && !proc_rd |=> avail_to_proc)
		else $error("processor flag dropped without a read");
	sequence s_low_then_high;
		mcu_wr_lo && !down_full ##1 mcu_wr_hi;
	endsequence
	AST_WORD_PASS: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R8
		s_low_then_high |=> avail_to_proc && down_word[15:8] == $past(mcu_wdata))
		else $error("two byte writes did not complete a word");
	AST_FAULT_CLR: assert property (@(posedge clk_sys) disable iff (!arst_n) // see R6
		fault_clr && !timed_out |=> !proc_comm_fault)
		else $error("fault not cleared");
endmodule // bwmb_bridge
`default_nettype wire

// ===== tb/bwmb_proc_model.sv
// processor-side model driving the 16-bit word port
// assumes tasks are called from the clk_sys domain
`default_nettype none
module bwmb_proc_model
	import bwmb_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// word port
	output logic proc_wr,
	output logic proc_rd,
	output logic [BWMB_WORD_W-1:0] proc_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		proc_wr = 1'b0;
		proc_rd = 1'b0;
		proc_wdata = 16'h0000;
	end
	// stale data is inverted so a late sample cannot pass
	task automatic put_word(input logic [15:0] d);
		@(posedge clk_sys);
		proc_wr <= 1'b1;
		proc_wdata <= d;
		@(posedge clk_sys);
		proc_wr <= 1'b0;
		proc_wdata <= ~d;
	endtask
	// dly lets the model answer promptly or slowly; one edge always passes
	// so the strobe is launched on a clock edge
	task automatic get_word(input int dly);
		repeat (dly + 1) @(posedge clk_sys);
		proc_rd <= 1'b1;
		@(posedge clk_sys);
		proc_rd <= 1'b0;
	endtask
endmodule // bwmb_proc_model
`default_nettype wire

// ===== tb/byte_to_word_mailbox_bridge_tb.sv
// bench for the mailbox bridge: controller byte tasks plus processor model
// assumes a short fault timeout so the fault shows quickly
`default_nettype none
module byte_to_word_mailbox_bridge_tb
	import bwmb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TO = 20;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic mcu_wr = 1'b0;
	logic mcu_rd = 1'b0;
	logic mcu_sel = 1'b0;
	logic fault_clr = 1'b0;
	logic [7:0] mcu_wdata = 8'h00;
	logic [7:0] mcu_rdata;
	logic proc_wr;
	logic proc_rd;
	logic [15:0] proc_wdata;
	logic [15:0] proc_rdata;
	logic avail_to_mcu;
	logic avail_to_proc;
	logic proc_comm_fault;
	int errors = 0;
	int num_checks = 0;
	bwmb_bridge #(.TIMEOUT_CYC(TO)) u_dut (.clk_sys, .arst_n, .mcu_wr, .mcu_rd, .mcu_sel, .mcu_wdata,
		.mcu_rdata, .proc_wr, .proc_rd, .proc_wdata, .proc_rdata, .avail_to_mcu, .avail_to_proc,
		.proc_comm_fault, .fault_clr);
	bwmb_proc_model u_proc (.clk_sys, .proc_wr, .proc_rd, .proc_wdata);
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// low byte must lead, high byte completes the word
	task automatic mcu_put(input logic [15:0] w);
		@(posedge clk_sys);
		mcu_wr <= 1'b1;
		mcu_sel <= BWMB_SEL_LO;
		mcu_wdata <= w[7:0];
		@(posedge clk_sys);
		mcu_sel <= BWMB_SEL_HI;
		mcu_wdata <= w[15:8];
		@(posedge clk_sys);
		mcu_wr <= 1'b0;
		mcu_wdata <= ~w[15:8];
		#1;
	endtask
	task automatic t_down;
		mcu_put(16'hA55A);
		chk("avail_to_proc", 16'h1, {15'h0, avail_to_proc});
		u_proc.get_word(4);
		#1 chk("proc_rdata", 16'hA55A, proc_rdata);
		chk("avail_to_proc", 16'h0, {15'h0, avail_to_proc});
		chk("fault none", 16'h0, {15'h0, proc_comm_fault});
		u_proc.get_word(0);
		#1 chk("proc_rdata held", 16'hA55A, proc_rdata);
		$display("test down done");
	endtask
	task automatic t_up;
		u_proc.put_word(16'h3CC3);
		#1 chk("avail_to_mcu", 16'h1, {15'h0, avail_to_mcu});
		u_proc.put_word(16'hFFFF);
		@(posedge clk_sys);
		mcu_rd <= 1'b1;
		mcu_sel <= BWMB_SEL_LO;
		@(posedge clk_sys);
		mcu_sel <= BWMB_SEL_HI;
		#1 chk("mcu_rdata lo", 16'h00C3, {8'h00, mcu_rdata});
		@(posedge clk_sys);
		mcu_rd <= 1'b0;
		#1 chk("mcu_rdata hi", 16'h003C, {8'h00, mcu_rdata});
		@(posedge clk_sys);
		#1 chk("avail_to_mcu", 16'h0, {15'h0, avail_to_mcu});
		$display("test up done");
	endtask
	task automatic t_fault;
		mcu_put(16'h1234);
		repeat (TO - 1) @(posedge clk_sys);
		#1 chk("fault early", 16'h0, {15'h0, proc_comm_fault});
		@(posedge clk_sys);
		#1 chk("fault", 16'h1, {15'h0, proc_comm_fault});
		@(posedge clk_sys);
		fault_clr <= 1'b1;
		@(posedge clk_sys);
		fault_clr <= 1'b0;
		#1 chk("fault clr", 16'h0, {15'h0, proc_comm_fault});
		mcu_put(16'h5AA5);
		u_proc.get_word(0);
		#1 chk("proc_rdata", 16'h1234, proc_rdata);
		chk("avail_to_proc", 16'h0, {15'h0, avail_to_proc});
		$display("test fault done");
	endtask
	initial
	begin
		#100000;
		errors++;
		final_report();
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1 chk("reset flags", 16'h0, {13'h0, avail_to_mcu, avail_to_proc, proc_comm_fault});
		t_down();
		t_up();
		t_fault();
		final_report();
	end
endmodule // byte_to_word_mailbox_bridge_tb
`default_nettype wire
